// >>> hw/cls_pkg.sv
`default_nettype none

package cls_pkg;

  // Register map, byte addresses on the 32-bit register bus
  localparam int unsigned CLS_AXI_AW = 8;
  localparam logic [7:0] CLS_OFF_INSTR = 8'h00;
  localparam logic [7:0] CLS_OFF_STATUS = 8'h04;
  localparam logic [7:0] CLS_OFF_LAST_ADDR = 8'h08;
  localparam logic [7:0] CLS_OFF_GPR_BASE = 8'h40;
  localparam logic [7:0] CLS_GPR_SPAN_MASK = 8'hE0;

  // Status register bit positions
  localparam int unsigned CLS_ST_BUSY = 0;
  localparam int unsigned CLS_ST_DONE = 1;
  localparam int unsigned CLS_ST_UNDEF = 2;
  localparam int unsigned CLS_ST_REFUSED = 3;

  // Reset values
  localparam logic [15:0] CLS_INSTR_RST = 16'h0000;
  localparam logic [31:0] CLS_GPR_RST = 32'h0000_0000;

  // Instruction field positions
  localparam int unsigned CLS_F_XFER_LSB = 0;
  localparam int unsigned CLS_F_BASE_LSB = 3;
  localparam int unsigned CLS_F_OFFS_LSB = 6;
  localparam int unsigned CLS_F_IMM_LSB = 6;
  localparam int unsigned CLS_F_SEL_LSB = 3;
  localparam logic [3:0] CLS_GRP_REG_TAG = 4'h5;
  localparam logic [2:0] CLS_GRP_IMM_TAG = 3'h3;

  // AXI response codes
  localparam logic [1:0] CLS_RESP_OKAY = 2'h0;
  localparam logic [1:0] CLS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CLS_SZ_BYTE = 2'h0,
    CLS_SZ_HALF = 2'h1,
    CLS_SZ_WORD = 2'h2
  } cls_size_t;

  typedef enum logic [4:0] {
    CLS_SEL_INSTR = 5'h01,
    CLS_SEL_STATUS = 5'h02,
    CLS_SEL_LAST_ADDR = 5'h04,
    CLS_SEL_GPR = 5'h08,
    CLS_SEL_NONE = 5'h10
  } cls_sel_t;

  typedef struct packed {
    logic valid;
    logic load;
    logic sign;
    cls_size_t size;
    logic imm;
    logic [6:0] imm_off;
    logic [2:0] xfer;
    logic [2:0] base;
    logic [2:0] offs;
  } cls_op_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    cls_size_t size;
    logic write;
  } cls_mem_req_t;

  function automatic cls_sel_t cls_decode_addr(input logic [7:0] a);
    cls_sel_t s;
    s = CLS_SEL_NONE;
    if (a[1:0] != 2'h0) s = CLS_SEL_NONE;
    else if (a == CLS_OFF_INSTR) s = CLS_SEL_INSTR;
    else if (a == CLS_OFF_STATUS) s = CLS_SEL_STATUS;
    else if (a == CLS_OFF_LAST_ADDR) s = CLS_SEL_LAST_ADDR;
    else if ((a & CLS_GPR_SPAN_MASK) == CLS_OFF_GPR_BASE) s = CLS_SEL_GPR;
    return s;
  endfunction : cls_decode_addr

endpackage : cls_pkg

`default_nettype wire

// >>> hw/cls_reg_bank.sv
`default_nettype none

// Small register file; every read port returns data one cycle after its address
module cls_reg_bank #(
  parameter int unsigned DW = 32,
  parameter int unsigned AW = 3,
  parameter int unsigned NRD = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NRD-1:0][AW-1:0] raddr,
  output logic [NRD-1:0][DW-1:0] rdata,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW/8-1:0] wbe,
  input wire logic [DW-1:0] wdata
);
  import cls_pkg::*;

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge aclk) begin
    for (int i = 0; i < (1 << AW); i++) begin
      if (!aresetn) begin
        mem[i] <= DW'(CLS_GPR_RST);
      end else if (we && waddr == AW'(i)) begin
        for (int b = 0; b < DW / 8; b++) begin
          if (wbe[b]) mem[i][b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NRD; g++) begin : g_rd
      always_ff @(posedge aclk) begin
        if (!aresetn) rdata[g] <= '0;
        else rdata[g] <= mem[raddr[g]];
      end
    end
  endgenerate

endmodule : cls_reg_bank

`default_nettype wire

// >>> hw/cls_core.sv
// Functional notes
// - Register-offset group: address is base plus offset register, both 0-7, no writeback.
// - Register-offset, load/store 0 and byte/word 0: store transfer register as word.
// - Register-offset, load/store 0 and byte/word 1: store low byte of transfer register.
// - Register-offset, load/store 1 and byte/word 0: load word into transfer register.
// - Register-offset, load/store 1 and byte/word 1: load byte into transfer register.
// - Each compressed transfer takes the same cycles as its full-width equivalent.
// - Sign-extension group: byte/half loads, optionally signed, and halfword stores only.
// - Sign group, sign 0 half 0: store transfer register bits 0-15 at base+offset.
// - Sign group, sign 0 half 1: load halfword into bits 0-15, clear 16-31.
// - Sign group, sign 1 half 0: load byte, fill bits 8-31 with bit 7.
// - Sign group, sign 1 half 1: load halfword, fill bits 16-31 with bit 15.
// - Immediate group: address is base plus 5-bit, or 7-bit word, immediate.
// - Immediate group, load/store 1 and byte/word 0: load word at base plus immediate.
// - Immediate group, byte/word 1 and load/store 0: store byte at base plus immediate.
// - Immediate group, byte/word 1 and load/store 1: load byte at base plus immediate.
// - Immediate word offset is the 5-bit field shifted left by two.
// - Immediate byte offset is the 5-bit field unscaled.
`default_nettype none

module cls_core (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [cls_pkg::CLS_AXI_AW-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [cls_pkg::CLS_AXI_AW-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Data bus towards the memory system
  output logic mem_valid,
  output cls_pkg::cls_mem_req_t mem_cmd,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import cls_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_FETCH = 5'h02,
    ST_ISSUE = 5'h04,
    ST_WAIT = 5'h08,
    ST_WBACK = 5'h10
  } cls_state_t;

  // Decodes one 16-bit instruction of the three transfer groups
  function automatic cls_op_t decode_instr(input logic [15:0] ins);
    cls_op_t op;
    logic [4:0] imm5;
    op = '0;
    imm5 = ins[CLS_F_IMM_LSB +: 5];
    op.xfer = ins[CLS_F_XFER_LSB +: 3];
    op.base = ins[CLS_F_BASE_LSB +: 3];
    op.offs = ins[CLS_F_OFFS_LSB +: 3];
    op.size = CLS_SZ_WORD;
    if (ins[15:12] == CLS_GRP_REG_TAG && !ins[9]) begin
      op.valid = 1'b1;
      op.load = ins[11];
      op.size = ins[10] ? CLS_SZ_BYTE : CLS_SZ_WORD;
    end else if (ins[15:12] == CLS_GRP_REG_TAG && ins[9]) begin
      // Bit 11 is the halfword select, bit 10 the sign-extend select
      op.valid = 1'b1;
      op.load = ins[11] | ins[10];
      op.sign = ins[10];
      op.size = (ins[10] && !ins[11]) ? CLS_SZ_BYTE : CLS_SZ_HALF;
    end else if (ins[15:13] == CLS_GRP_IMM_TAG) begin
      op.valid = 1'b1;
      op.imm = 1'b1;
      op.load = ins[11];
      op.size = ins[12] ? CLS_SZ_BYTE : CLS_SZ_WORD;
      op.imm_off = ins[12] ? {2'h0, imm5} : {imm5, 2'h0};
    end
    return op;
  endfunction : decode_instr

  // Fits loaded data to the transfer register width
  function automatic logic [31:0] extend_load(input cls_size_t sz, input logic sgn, input logic [31:0] d);
    logic [31:0] r;
    r = d;
    if (sz == CLS_SZ_BYTE) r = {{24{sgn & d[7]}}, d[7:0]};
    else if (sz == CLS_SZ_HALF) r = {{16{sgn & d[15]}}, d[15:0]};
    return r;
  endfunction : extend_load

  // Write channel state
  logic aw_held;
  logic w_held;
  logic [CLS_AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_byte_store_q;
  // Read channel state
  logic rd_pend;
  logic [CLS_AXI_AW-1:0] ar_addr_q;
  // Executor state
  cls_state_t state;
  cls_op_t op_q;
  logic [15:0] instr_q;
  logic [31:0] last_addr;
  logic [31:0] load_data;
  logic flag_done;
  logic flag_undef;
  logic flag_refused;
  // Register bank
  logic [3:0][2:0] rb_raddr;
  logic [3:0][31:0] rb_rdata;
  logic rb_we;
  logic [2:0] rb_waddr;
  logic [3:0] rb_wbe;
  logic [31:0] rb_wdata;

  wire logic aw_hs = s_awvalid & s_awready;
  wire logic w_hs = s_wvalid & s_wready;
  wire logic ar_hs = s_arvalid & s_arready;
  wire logic do_write = aw_held & w_held & ~s_bvalid;
  wire cls_sel_t wsel = cls_decode_addr(aw_addr_q);
  wire cls_sel_t rsel = cls_decode_addr(ar_addr_q);
  wire logic idle = (state == ST_IDLE);
  wire logic wr_instr = do_write & (wsel == CLS_SEL_INSTR);
  wire logic wr_status = do_write & (wsel == CLS_SEL_STATUS);
  wire logic wr_gpr = do_write & (wsel == CLS_SEL_GPR);
  // Instruction and register writes during a transfer would corrupt its operands, so they are refused
  wire logic wr_blocked = (wr_instr | wr_gpr) & ~idle;
  wire logic wr_bad = do_write & (wsel == CLS_SEL_NONE || wsel == CLS_SEL_LAST_ADDR);
  wire logic [15:0] next_instr = {w_byte_store_q[1] ? w_data_q[15:8] : instr_q[15:8],
                                  w_byte_store_q[0] ? w_data_q[7:0] : instr_q[7:0]};
  wire logic start = wr_instr & idle;
  wire cls_op_t new_op = decode_instr(next_instr);

  wire logic next_aw_held = do_write ? 1'b0 : (aw_hs | aw_held);
  wire logic next_w_held = do_write ? 1'b0 : (w_hs | w_held);
  wire logic next_bvalid = do_write | (s_bvalid & ~s_bready);
  wire logic next_rvalid = rd_pend | (s_rvalid & ~s_rready);
  wire logic next_rd_pend = ar_hs;

  // Operand values arrive registered from the bank during ISSUE
  wire logic [31:0] base_val = rb_rdata[0];
  wire logic [31:0] offs_val = op_q.imm ? {25'h0, op_q.imm_off} : rb_rdata[1];
  wire logic [31:0] xfer_addr = base_val + offs_val;
  wire logic [31:0] xfer_val = rb_rdata[2];
  wire logic [31:0] store_data = (op_q.size == CLS_SZ_BYTE) ? {24'h0, xfer_val[7:0]} :
                                 (op_q.size == CLS_SZ_HALF) ? {16'h0, xfer_val[15:0]} :
                                 xfer_val;
  wire logic [31:0] status_word = {28'h0, flag_refused, flag_undef, flag_done, ~idle};

  wire logic [31:0] read_word = (rsel == CLS_SEL_INSTR) ? {16'h0, instr_q} :
                                (rsel == CLS_SEL_STATUS) ? status_word :
                                (rsel == CLS_SEL_LAST_ADDR) ? last_addr :
                                (rsel == CLS_SEL_GPR) ? rb_rdata[3] : 32'h0000_0000;

  assign rb_raddr[0] = op_q.base;
  assign rb_raddr[1] = op_q.offs;
  assign rb_raddr[2] = op_q.xfer;
  assign rb_raddr[3] = s_araddr[4:2];
  // Load writeback and software writes never overlap: software writes only land while idle
  assign rb_we = (state == ST_WBACK) | (wr_gpr & idle);
  assign rb_waddr = (state == ST_WBACK) ? op_q.xfer : aw_addr_q[4:2];
  assign rb_wbe = (state == ST_WBACK) ? 4'hF : w_byte_store_q;
  assign rb_wdata = (state == ST_WBACK) ? load_data : w_data_q;

  cls_reg_bank #(
    .DW(32),
    .AW(3),
    .NRD(4)
  ) u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .raddr(rb_raddr),
    .rdata(rb_rdata),
    .we(rb_we),
    .waddr(rb_waddr),
    .wbe(rb_wbe),
    .wdata(rb_wdata)
  );

  // AXI write channels: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= CLS_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_awready <= ~next_aw_held & ~next_bvalid;
      s_wready <= ~next_w_held & ~next_bvalid;
      s_bvalid <= next_bvalid;
      if (do_write) s_bresp <= (wr_blocked | wr_bad) ? CLS_RESP_SLVERR : CLS_RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_byte_store_q <= 4'h0;
    end else begin
      if (aw_hs) aw_addr_q <= s_awaddr;
      if (w_hs) w_data_q <= s_wdata;
      if (w_hs) w_byte_store_q <= s_wstrb;
    end
  end

  // AXI read channel: data two cycles after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend <= 1'b0;
      ar_addr_q <= '0;
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= CLS_RESP_OKAY;
    end else begin
      rd_pend <= next_rd_pend;
      s_arready <= ~next_rd_pend & ~next_rvalid;
      s_rvalid <= next_rvalid;
      if (ar_hs) ar_addr_q <= s_araddr;
      if (rd_pend) s_rdata <= read_word;
      if (rd_pend) s_rresp <= (rsel == CLS_SEL_NONE) ? CLS_RESP_SLVERR : CLS_RESP_OKAY;
    end
  end

  // Sticky flags: a setting event in the same cycle as a clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_done <= 1'b0;
      flag_undef <= 1'b0;
      flag_refused <= 1'b0;
    end else begin
      flag_done <= ((state == ST_WAIT && mem_ack && !op_q.load) || state == ST_WBACK) |
                   (flag_done & ~(wr_status & w_byte_store_q[0] & w_data_q[CLS_ST_DONE]));
      flag_undef <= (start & ~new_op.valid) |
                    (flag_undef & ~(wr_status & w_byte_store_q[0] & w_data_q[CLS_ST_UNDEF]));
      flag_refused <= wr_blocked |
                      (flag_refused & ~(wr_status & w_byte_store_q[0] & w_data_q[CLS_ST_REFUSED]));
    end
  end

  // The sequence is shared by every width and group, so each compressed form costs the same
  // cycles as its full-width equivalent: stores FETCH-ISSUE-WAIT, loads add one WBACK cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      op_q <= '0;
      instr_q <= CLS_INSTR_RST;
      last_addr <= 32'h0000_0000;
      load_data <= 32'h0000_0000;
      mem_valid <= 1'b0;
      mem_cmd <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            instr_q <= next_instr;
            op_q <= new_op;
            if (new_op.valid) state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state <= ST_ISSUE;
        end
        ST_ISSUE: begin
          mem_valid <= 1'b1;
          mem_cmd.addr <= xfer_addr;
          mem_cmd.wdata <= op_q.load ? 32'h0000_0000 : store_data;
          mem_cmd.size <= op_q.size;
          mem_cmd.write <= ~op_q.load;
          last_addr <= xfer_addr;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (mem_ack) begin
            mem_valid <= 1'b0;
            load_data <= extend_load(op_q.size, op_q.sign, mem_rdata);
            state <= op_q.load ? ST_WBACK : ST_IDLE;
          end
        end
        ST_WBACK: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : cls_core

`default_nettype wire

// >>> verif/cls_core_properties.sv
`default_nettype none
module cls_core_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_awready,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic mem_valid,
  input wire cls_pkg::cls_mem_req_t mem_cmd,
  input wire logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  import cls_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_cmd_stable: assert property (mem_valid && !mem_ack |=> mem_valid && $stable(mem_cmd))
    else $error("memory request changed before ack");
  a_ack_ends: assert property (mem_valid && mem_ack |=> !mem_valid)
    else $error("memory request kept after ack");
  a_byte_upper: assert property (mem_valid && mem_cmd.write && mem_cmd.size == CLS_SZ_BYTE |->
    mem_cmd.wdata[31:8] == 24'h0) else $error("byte store upper bits not zero");
  a_half_upper: assert property (mem_valid && mem_cmd.write && mem_cmd.size == CLS_SZ_HALF |->
    mem_cmd.wdata[31:16] == 16'h0) else $error("half store upper bits not zero");
  a_read_lat: assert property (s_arvalid && s_arready |-> ##2 s_rvalid)
    else $error("read answer late");
  a_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  a_ready_gap: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write accepted during response");
endmodule : cls_core_properties

bind cls_core cls_core_properties i_props (.aclk, .aresetn, .s_awready, .s_wready, .s_bresp, .s_bvalid,
  .s_bready, .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready, .mem_valid, .mem_cmd, .mem_ack);
`default_nettype wire

// >>> verif/cls_mem_model.sv
`default_nettype none
// Memory side: acks after a bench-chosen wait; data lines toggle outside the ack cycle
module cls_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_valid,
  input wire logic [3:0] wait_cycles,
  input wire logic [31:0] load_value,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] count;
  always_ff @(posedge aclk) begin
    if (!aresetn || !mem_valid || mem_ack) count <= 4'h0;
    else count <= count + 4'h1;
  end
  assign mem_ack = mem_valid && (count >= wait_cycles);
  assign mem_rdata = mem_ack ? load_value : ~load_value;
endmodule : cls_mem_model
`default_nettype wire

// >>> verif/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cls_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0, s_rdata, mem_rdata, load_v = 32'h0;
  logic [3:0] s_wstrb = 4'hF, wait_c = 4'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, mem_valid, mem_ack, rd_chk = 1'b0;
  logic [1:0] s_bresp, s_rresp;
  cls_mem_req_t mem_cmd;
  logic [31:0] gpr [8], rng = 32'h10;
  int miscompares = 0, n_compared = 0;
  // Edges from the instruction write's response to the first edge that sees the memory request
  localparam int ISSUE_GAP = 2;
  time t_b = 0, t_mv = 0;
  logic mv_d = 1'b0;
  cls_mem_req_t exp_m [$];
  logic [1:0] exp_b [$];
  logic [33:0] exp_r [$];
  always #4 aclk = ~aclk;
  cls_core i_dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .mem_valid, .mem_cmd, .mem_ack, .mem_rdata);
  cls_mem_model i_mem (.aclk, .aresetn, .mem_valid, .wait_cycles(wait_c), .load_value(load_v), .mem_ack,
    .mem_rdata);
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  task automatic finish_test();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [66:0] g, input logic [66:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic guard(input int n);
    if (n >= 60) begin
      miscompares++;
      $display("ERROR %0t: wait timed out", $time);
      finish_test();
    end
  endtask : guard
  always @(posedge aclk) begin
    if (mem_valid && mem_ack) check(mem_cmd, exp_m.size() > 0 ? exp_m.pop_front() : 'x);
    if (s_bvalid && s_bready) check(67'(s_bresp), 67'(exp_b.pop_front()));
    if (s_rvalid && s_rready && rd_chk) check(67'({s_rresp, s_rdata}), 67'(exp_r.pop_front()));
    if (mem_valid && !mv_d) t_mv = $time;
    mv_d = mem_valid;
  end
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic ad, wd;
    @(posedge aclk);
    exp_b.push_back(e);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (!ad && s_awready) begin ad = 1'b1; s_awvalid <= 1'b0; end
      if (!wd && s_wready) begin wd = 1'b1; s_wvalid <= 1'b0; end
    end while (!(ad && wd) && n < 60);
    while (s_bvalid !== 1'b1 && n < 60) begin @(posedge aclk); n++; end
    s_bready <= 1'b0;
    guard(n);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, input logic chk, input logic [33:0] e, output logic [31:0] d);
    int n;
    @(posedge aclk);
    if (chk) exp_r.push_back(e);
    rd_chk <= chk;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (s_arready !== 1'b1 && n < 60);
    s_arvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (s_rvalid !== 1'b1 && n < 60);
    d = s_rdata;
    s_rready <= 1'b0;
    guard(n);
  endtask : axi_read
  // Groups by k[3:2]: register offset, sign group, immediate offset
  task automatic run_op(input logic [3:0] k, input logic slow);
    logic [31:0] t, lv, ld, d;
    logic [2:0] x, b, o;
    logic [4:0] im;
    logic [15:0] ins;
    cls_mem_req_t r;
    int n;
    t = xs();
    lv = xs();
    x = t[2:0];
    b = t[5:3];
    o = t[8:6];
    im = t[13:9];
    if (k[3:2] == 2'h0) ins = {4'h5, k[1], k[0], 1'b0, o, b, x};
    else if (k[3:2] == 2'h1) ins = {4'h5, k[0], k[1], 1'b1, o, b, x};
    else ins = {3'h3, k[0], k[1], im, b, x};
    r.addr = gpr[b] + (k[3] ? (k[0] ? {27'h0, im} : {25'h0, im, 2'h0}) : gpr[o]);
    r.write = (k[3:2] == 2'h1) ? (k == 4'h4) : !k[1];
    r.size = (k[3:2] == 2'h1) ? ((k == 4'h6) ? CLS_SZ_BYTE : CLS_SZ_HALF) : (k[0] ? CLS_SZ_BYTE : CLS_SZ_WORD);
    // Loads carry no data towards memory
    r.wdata = !r.write ? 32'h0 : (r.size == CLS_SZ_BYTE) ? {24'h0, gpr[x][7:0]} :
      (r.size == CLS_SZ_HALF) ? {16'h0, gpr[x][15:0]} : gpr[x];
    if (r.size == CLS_SZ_BYTE) ld = (k == 4'h6) ? {{24{lv[7]}}, lv[7:0]} : {24'h0, lv[7:0]};
    else if (r.size == CLS_SZ_HALF) ld = (k == 4'h7) ? {{16{lv[15]}}, lv[15:0]} : {16'h0, lv[15:0]};
    else ld = lv;
    wait_c <= slow ? 4'hF : {2'h0, t[15:14]};
    load_v <= lv;
    exp_m.push_back(r);
    axi_write(CLS_OFF_INSTR, {16'h0, ins}, CLS_RESP_OKAY);
    t_b = $time;
    if (slow) axi_write(CLS_OFF_INSTR, 32'h0, CLS_RESP_SLVERR);
    n = 0;
    do begin axi_read(CLS_OFF_STATUS, 1'b0, 34'h0, d); n++; end while (d[1] !== 1'b1 && n < 60);
    guard(n);
    check(67'((t_mv - t_b) / 8), 67'(ISSUE_GAP));
    axi_read(CLS_OFF_STATUS, 1'b1, {30'h0, slow, 3'h2}, d);
    axi_read(CLS_OFF_LAST_ADDR, 1'b1, {2'h0, r.addr}, d);
    if (!r.write) gpr[x] = ld;
    axi_read(CLS_OFF_GPR_BASE + {3'h0, x, 2'h0}, 1'b1, {2'h0, gpr[x]}, d);
    axi_read(CLS_OFF_GPR_BASE + {3'h0, b, 2'h0}, 1'b1, {2'h0, gpr[b]}, d);
    axi_write(CLS_OFF_STATUS, 32'hE, CLS_RESP_OKAY);
  endtask : run_op
  initial begin
    logic [31:0] d;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      gpr[n] = xs();
      axi_write(CLS_OFF_GPR_BASE + 8'(4 * n), gpr[n], CLS_RESP_OKAY);
    end
    for (int p = 0; p < 3; p++)
      for (int k = 0; k < 12; k++) run_op(4'(k), p == 0);
    axi_write(CLS_OFF_INSTR, 32'h0000_FFFF, CLS_RESP_OKAY);
    axi_read(CLS_OFF_STATUS, 1'b1, 34'h4, d);
    axi_read(CLS_OFF_INSTR, 1'b1, 34'h0_0000_FFFF, d);
    axi_write(CLS_OFF_LAST_ADDR, 32'h1, CLS_RESP_SLVERR);
    axi_read(8'hF0, 1'b1, {CLS_RESP_SLVERR, 32'h0}, d);
    // Only byte lane 0 of register 0 may change
    s_wstrb <= 4'h1;
    axi_write(CLS_OFF_GPR_BASE, 32'h5A5A_5AA5, CLS_RESP_OKAY);
    s_wstrb <= 4'hF;
    axi_read(CLS_OFF_GPR_BASE, 1'b1, {2'h0, gpr[0][31:8], 8'hA5}, d);
    repeat (4) @(posedge aclk);
    check(67'(exp_m.size() + exp_b.size() + exp_r.size()), 67'(0));
    finish_test();
  end
endmodule : testbench
`default_nettype wire
